// file: rtl/bus_voltage_threshold_regs.sv
// Threshold register bank with monitor, fault flag and hiccup restart
// Notes on behaviour
// RQ1 - Low bus OV warning code decode
// RQ2 - Low bus OV protection code decode
// RQ3 - Low bus UV warning code decode
// RQ4 - High bus UV warning code decode
// RQ5 - High bus OV register layout, top reserved
// RQ6 - Byte registers, read/write, protectable, reset zero
// RQ7 - UV register layout, top reserved
// RQ8 - Thresholds apply regardless of bus direction
// RQ9 - High bus OV warning code decode
// RQ10 - High bus OV protection code decode
// RQ11 - Protection trip: status, flag low, hiccup
// RQ12 - New code used at next comparison
`timescale 1ns/1ps
module bus_voltage_threshold_regs #(
  parameter int V_W = 16,
  parameter int HICCUP_CYCLES = threshold_pkg::HICCUP_CYCLES
) (
  input wire logic clock_i,
  input wire logic rst_n_i,
  input wire logic [threshold_pkg::DATA_W-1:0] cmd_code_i,
  input wire logic wr_stb_i,
  input wire logic [threshold_pkg::DATA_W-1:0] wr_data_i,
  input wire logic rd_stb_i,
  input wire logic write_protect_i,
  output logic [threshold_pkg::DATA_W-1:0] rd_data_o,
  output logic rd_valid_o,
  output logic cmd_unsupported_o,
  input wire logic sample_i,
  input wire logic [V_W-1:0] low_bus_voltage_i,
  input wire logic [V_W-1:0] low_bus_target_i,
  input wire logic [V_W-1:0] high_bus_voltage_i,
  input wire logic [V_W-1:0] high_bus_target_i,
  input wire logic hiccup_mode_i,
  input wire logic [1:0] fault_clear_i,
  output logic [1:0] fault_status_o,
  output logic [3:0] warning_o,
  output logic fault_flag_n_o,
  output logic switching_enable_o
);
  localparam int CNT_W = $clog2(HICCUP_CYCLES + 1);
  localparam logic [CNT_W-1:0] HICCUP_LAST = CNT_W'(HICCUP_CYCLES - 1);

  logic rst_sync1_r;
  logic rst_sync2_r;
  logic rst_n;

  logic [threshold_pkg::DATA_W-1:0] low_bus_overvoltage_thresholds_r;
  logic [threshold_pkg::DATA_W-1:0] low_bus_overvoltage_thresholds_nxt;
  logic [threshold_pkg::DATA_W-1:0] undervoltage_warning_thresholds_r;
  logic [threshold_pkg::DATA_W-1:0] undervoltage_warning_thresholds_nxt;
  logic [threshold_pkg::DATA_W-1:0] high_bus_overvoltage_thresholds_r;
  logic [threshold_pkg::DATA_W-1:0] high_bus_overvoltage_thresholds_nxt;
  logic [threshold_pkg::DATA_W-1:0] rd_data_r;
  logic [threshold_pkg::DATA_W-1:0] rd_data_nxt;
  logic rd_valid_r;
  logic rd_valid_nxt;
  logic unsupported_r;
  logic unsupported_nxt;

  logic [1:0] fault_status_r;
  logic [1:0] fault_status_nxt;
  logic fault_flag_n_r;
  logic fault_flag_n_nxt;
  threshold_pkg::hiccup_state_e state_r;
  threshold_pkg::hiccup_state_e state_nxt;
  logic [CNT_W-1:0] wait_cnt_r;
  logic [CNT_W-1:0] wait_cnt_nxt;
  logic switching_r;
  logic switching_nxt;
  logic prot_hit;

  threshold_if thr ();

  // Reset release through two flops
  always_ff @(posedge clock_i or negedge rst_n_i) begin
    if (!rst_n_i) begin
      rst_sync1_r <= 1'b0;
      rst_sync2_r <= 1'b0;
    end else begin
      rst_sync1_r <= 1'b1;
      rst_sync2_r <= rst_sync1_r;
    end
  end
  assign rst_n = rst_sync2_r;

  function automatic logic [threshold_pkg::DATA_W-1:0] read_mux(
      input logic [threshold_pkg::DATA_W-1:0] code,
      input logic [threshold_pkg::DATA_W-1:0] low_ov,
      input logic [threshold_pkg::DATA_W-1:0] uv,
      input logic [threshold_pkg::DATA_W-1:0] high_ov);
    unique case (code)
      threshold_pkg::LOW_OV_ADDR: read_mux = low_ov;
      threshold_pkg::UV_ADDR: read_mux = uv;
      threshold_pkg::HIGH_OV_ADDR: read_mux = high_ov;
      default: read_mux = threshold_pkg::READ_NONE;
    endcase
  endfunction

  // Register writes and reads
  always_comb begin
    low_bus_overvoltage_thresholds_nxt = low_bus_overvoltage_thresholds_r;
    undervoltage_warning_thresholds_nxt = undervoltage_warning_thresholds_r;
    high_bus_overvoltage_thresholds_nxt = high_bus_overvoltage_thresholds_r;
    rd_data_nxt = rd_data_r;
    rd_valid_nxt = 1'b0;
    unsupported_nxt = 1'b0;
    if (wr_stb_i && !write_protect_i) begin // RQ6
      unique case (cmd_code_i)
        threshold_pkg::LOW_OV_ADDR:
          low_bus_overvoltage_thresholds_nxt = wr_data_i & threshold_pkg::FIELD_MASK;
        threshold_pkg::UV_ADDR:
          undervoltage_warning_thresholds_nxt = wr_data_i & threshold_pkg::FIELD_MASK; // RQ7
        threshold_pkg::HIGH_OV_ADDR:
          high_bus_overvoltage_thresholds_nxt = wr_data_i & threshold_pkg::FIELD_MASK; // RQ5
        default: unsupported_nxt = 1'b1;
      endcase
    end
    if (rd_stb_i) begin
      rd_data_nxt = read_mux(cmd_code_i, low_bus_overvoltage_thresholds_r,
                             undervoltage_warning_thresholds_r,
                             high_bus_overvoltage_thresholds_r); // RQ6
      rd_valid_nxt = 1'b1;
      unsupported_nxt = rd_data_nxt == threshold_pkg::READ_NONE &&
                        cmd_code_i != threshold_pkg::LOW_OV_ADDR &&
                        cmd_code_i != threshold_pkg::UV_ADDR &&
                        cmd_code_i != threshold_pkg::HIGH_OV_ADDR;
    end
  end

  always_ff @(posedge clock_i or negedge rst_n) begin
    if (!rst_n) begin
      low_bus_overvoltage_thresholds_r <= threshold_pkg::REG_RESET; // RQ6
      undervoltage_warning_thresholds_r <= threshold_pkg::REG_RESET;
      high_bus_overvoltage_thresholds_r <= threshold_pkg::REG_RESET;
      rd_data_r <= threshold_pkg::READ_NONE;
      rd_valid_r <= 1'b0;
      unsupported_r <= 1'b0;
    end else begin
      low_bus_overvoltage_thresholds_r <= low_bus_overvoltage_thresholds_nxt;
      undervoltage_warning_thresholds_r <= undervoltage_warning_thresholds_nxt;
      high_bus_overvoltage_thresholds_r <= high_bus_overvoltage_thresholds_nxt;
      rd_data_r <= rd_data_nxt;
      rd_valid_r <= rd_valid_nxt;
      unsupported_r <= unsupported_nxt;
    end
  end

  // Field extraction to the monitor
  assign thr.low_ov_warn_code = low_bus_overvoltage_thresholds_r[
    threshold_pkg::WARN_LSB +: threshold_pkg::CODE_W]; // RQ1
  assign thr.low_ov_prot_code = low_bus_overvoltage_thresholds_r[
    threshold_pkg::PROT_LSB +: threshold_pkg::CODE_W]; // RQ2
  assign thr.low_uv_warn_code = undervoltage_warning_thresholds_r[
    threshold_pkg::WARN_LSB +: threshold_pkg::CODE_W]; // RQ3
  assign thr.high_uv_warn_code = undervoltage_warning_thresholds_r[
    threshold_pkg::PROT_LSB +: threshold_pkg::CODE_W]; // RQ4
  assign thr.high_ov_warn_code = high_bus_overvoltage_thresholds_r[
    threshold_pkg::WARN_LSB +: threshold_pkg::CODE_W]; // RQ9
  assign thr.high_ov_prot_code = high_bus_overvoltage_thresholds_r[
    threshold_pkg::PROT_LSB +: threshold_pkg::CODE_W]; // RQ10

  threshold_compare #(
    .V_W(V_W)
  ) u_compare (
    .clock_i(clock_i),
    .rst_n_i(rst_n),
    .sample_i(sample_i),
    .low_bus_voltage_i(low_bus_voltage_i),
    .low_bus_target_i(low_bus_target_i),
    .high_bus_voltage_i(high_bus_voltage_i),
    .high_bus_target_i(high_bus_target_i),
    .thr(thr)
  );

  assign prot_hit = thr.low_ov_prot_hit | thr.high_ov_prot_hit;

  // Fault status, flag and hiccup sequencing
  always_comb begin
    fault_status_nxt = (fault_status_r & ~fault_clear_i) |
                       {thr.high_ov_prot_hit, thr.low_ov_prot_hit}; // RQ11
    fault_flag_n_nxt = ~|fault_status_nxt; // RQ11
    state_nxt = state_r;
    wait_cnt_nxt = wait_cnt_r;
    unique case (state_r)
      threshold_pkg::SW_RUN: begin
        if (prot_hit && hiccup_mode_i) begin
          state_nxt = threshold_pkg::SW_STOPPED; // RQ11
        end
      end
      threshold_pkg::SW_STOPPED: begin
        if (!prot_hit) begin
          state_nxt = threshold_pkg::SW_RESTART_WAIT;
          wait_cnt_nxt = '0;
        end
      end
      threshold_pkg::SW_RESTART_WAIT: begin
        if (prot_hit) begin
          state_nxt = threshold_pkg::SW_STOPPED;
        end else if (wait_cnt_r == HICCUP_LAST) begin
          state_nxt = threshold_pkg::SW_RUN; // RQ11
        end else begin
          wait_cnt_nxt = wait_cnt_r + CNT_W'(1);
        end
      end
      default: state_nxt = threshold_pkg::SW_RUN;
    endcase
    switching_nxt = state_nxt == threshold_pkg::SW_RUN;
  end

  always_ff @(posedge clock_i or negedge rst_n) begin
    if (!rst_n) begin
      fault_status_r <= 2'h0;
      fault_flag_n_r <= 1'b1;
      state_r <= threshold_pkg::SW_RUN;
      wait_cnt_r <= '0;
      switching_r <= 1'b1;
    end else begin
      fault_status_r <= fault_status_nxt;
      fault_flag_n_r <= fault_flag_n_nxt;
      state_r <= state_nxt;
      wait_cnt_r <= wait_cnt_nxt;
      switching_r <= switching_nxt;
    end
  end

  assign rd_data_o = rd_data_r;
  assign rd_valid_o = rd_valid_r;
  assign cmd_unsupported_o = unsupported_r;
  assign fault_status_o = fault_status_r;
  assign warning_o = {thr.high_ov_warn_hit, thr.high_uv_warn_hit,
                      thr.low_uv_warn_hit, thr.low_ov_warn_hit};
  assign fault_flag_n_o = fault_flag_n_r;
  assign switching_enable_o = switching_r;
endmodule

// file: rtl/threshold_pkg.sv
// Shared constants, tables and types for the bus voltage threshold registers
package threshold_pkg;
  localparam int CODE_W = 3;
  localparam int DATA_W = 8;
  localparam int PERMILLE_W = 12;
  localparam int TABLE_N = 8;

  // Register command codes
  localparam logic [DATA_W-1:0] LOW_OV_ADDR = 8'hB9;
  localparam logic [DATA_W-1:0] UV_ADDR = 8'hBA;
  localparam logic [DATA_W-1:0] HIGH_OV_ADDR = 8'hBB;

  // Field layout and reset
  localparam int WARN_LSB = 0;
  localparam int PROT_LSB = 3;
  localparam logic [DATA_W-1:0] REG_RESET = 8'h00;
  localparam logic [DATA_W-1:0] FIELD_MASK = 8'h3F;
  localparam logic [CODE_W-1:0] CODE_RESET = 3'h0;
  localparam logic [DATA_W-1:0] READ_NONE = 8'h00;

  // Thresholds in tenths of a percent of the bus target voltage
  localparam int PERMILLE_SCALE = 1000;
  typedef logic [PERMILLE_W-1:0] pm_table_t [TABLE_N];
  localparam pm_table_t LOW_OV_WARN_PM = '{12'h47E, 12'h44C, 12'h4B0, 12'h4E2,
                                           12'h514, 12'h546, 12'h578, 12'h5AA};
  localparam pm_table_t LOW_OV_PROT_PM = '{12'h5DC, 12'h578, 12'h514, 12'h640,
                                           12'h6A4, 12'h708, 12'h76C, 12'h7D0};
  localparam pm_table_t LOW_UV_WARN_PM = '{12'h352, 12'h339, 12'h320, 12'h307,
                                           12'h2EE, 12'h2D5, 12'h36B, 12'h384};
  localparam pm_table_t HIGH_UV_WARN_PM = '{12'h2EE, 12'h2C6, 12'h29E, 12'h276,
                                            12'h244, 12'h21C, 12'h316, 12'h33E};
  localparam pm_table_t HIGH_OV_WARN_PM = '{12'h438, 12'h44C, 12'h46A, 12'h492,
                                            12'h4BA, 12'h4E2, 12'h424, 12'h410};
  localparam pm_table_t HIGH_OV_PROT_PM = '{12'h4E2, 12'h50A, 12'h532, 12'h564,
                                            12'h58C, 12'h5B4, 12'h5DC, 12'h4BA};

  // Hiccup restart delay
  localparam int HICCUP_DELAY_MS = 500;
  localparam int CLOCK_MHZ = 250;
  localparam int HICCUP_CYCLES = HICCUP_DELAY_MS * CLOCK_MHZ * 1000;

  typedef enum logic [1:0] {
    SW_RUN = 2'b00,
    SW_STOPPED = 2'b01,
    SW_RESTART_WAIT = 2'b10
  } hiccup_state_e;

  // Code to threshold lookup
  function automatic logic [PERMILLE_W-1:0] permille(input pm_table_t tbl,
                                                     input logic [CODE_W-1:0] code);
    permille = tbl[code];
  endfunction
endpackage

// file: rtl/threshold_if.sv
// Threshold codes out to the comparator and crossing flags back
`timescale 1ns/1ps
interface threshold_if;
  logic [threshold_pkg::CODE_W-1:0] low_ov_warn_code;
  logic [threshold_pkg::CODE_W-1:0] low_ov_prot_code;
  logic [threshold_pkg::CODE_W-1:0] low_uv_warn_code;
  logic [threshold_pkg::CODE_W-1:0] high_uv_warn_code;
  logic [threshold_pkg::CODE_W-1:0] high_ov_warn_code;
  logic [threshold_pkg::CODE_W-1:0] high_ov_prot_code;
  logic low_ov_warn_hit;
  logic low_ov_prot_hit;
  logic low_uv_warn_hit;
  logic high_uv_warn_hit;
  logic high_ov_warn_hit;
  logic high_ov_prot_hit;

  modport regs (
    output low_ov_warn_code, low_ov_prot_code, low_uv_warn_code,
    output high_uv_warn_code, high_ov_warn_code, high_ov_prot_code,
    input low_ov_warn_hit, low_ov_prot_hit, low_uv_warn_hit,
    input high_uv_warn_hit, high_ov_warn_hit, high_ov_prot_hit
  );
  modport cmp (
    input low_ov_warn_code, low_ov_prot_code, low_uv_warn_code,
    input high_uv_warn_code, high_ov_warn_code, high_ov_prot_code,
    output low_ov_warn_hit, low_ov_prot_hit, low_uv_warn_hit,
    output high_uv_warn_hit, high_ov_warn_hit, high_ov_prot_hit
  );
endinterface

// file: rtl/threshold_compare.sv
// Compares both bus voltages against the decoded thresholds each sample
`timescale 1ns/1ps
module threshold_compare #(
  parameter int V_W = 16
) (
  input wire logic clock_i,
  input wire logic rst_n_i,
  input wire logic sample_i,
  input wire logic [V_W-1:0] low_bus_voltage_i,
  input wire logic [V_W-1:0] low_bus_target_i,
  input wire logic [V_W-1:0] high_bus_voltage_i,
  input wire logic [V_W-1:0] high_bus_target_i,
  threshold_if.cmp thr
);
  localparam int P_W = V_W + threshold_pkg::PERMILLE_W;

  logic [5:0] hit_r;
  logic [5:0] hit_nxt;

  // Scaled compare: v * 1000 against target * permille
  function automatic logic above(input logic [V_W-1:0] v, input logic [V_W-1:0] t,
                                 input logic [threshold_pkg::PERMILLE_W-1:0] pm);
    logic [P_W-1:0] lhs;
    logic [P_W-1:0] rhs;
    lhs = P_W'(v) * P_W'(threshold_pkg::PERMILLE_SCALE);
    rhs = P_W'(t) * P_W'(pm);
    above = lhs > rhs;
  endfunction

  function automatic logic below(input logic [V_W-1:0] v, input logic [V_W-1:0] t,
                                 input logic [threshold_pkg::PERMILLE_W-1:0] pm);
    logic [P_W-1:0] lhs;
    logic [P_W-1:0] rhs;
    lhs = P_W'(v) * P_W'(threshold_pkg::PERMILLE_SCALE);
    rhs = P_W'(t) * P_W'(pm);
    below = lhs < rhs;
  endfunction

  // Bus role (input or output) does not enter the compare
  always_comb begin
    hit_nxt = hit_r;
    if (sample_i) begin
      hit_nxt[0] = above(low_bus_voltage_i, low_bus_target_i, threshold_pkg::permille(
        threshold_pkg::LOW_OV_WARN_PM, thr.low_ov_warn_code)); // RQ1 RQ8 RQ12
      hit_nxt[1] = above(low_bus_voltage_i, low_bus_target_i, threshold_pkg::permille(
        threshold_pkg::LOW_OV_PROT_PM, thr.low_ov_prot_code)); // RQ2 RQ8 RQ12
      hit_nxt[2] = below(low_bus_voltage_i, low_bus_target_i, threshold_pkg::permille(
        threshold_pkg::LOW_UV_WARN_PM, thr.low_uv_warn_code)); // RQ3 RQ8
      hit_nxt[3] = below(high_bus_voltage_i, high_bus_target_i, threshold_pkg::permille(
        threshold_pkg::HIGH_UV_WARN_PM, thr.high_uv_warn_code)); // RQ4 RQ8
      hit_nxt[4] = above(high_bus_voltage_i, high_bus_target_i, threshold_pkg::permille(
        threshold_pkg::HIGH_OV_WARN_PM, thr.high_ov_warn_code)); // RQ9 RQ8
      hit_nxt[5] = above(high_bus_voltage_i, high_bus_target_i, threshold_pkg::permille(
        threshold_pkg::HIGH_OV_PROT_PM, thr.high_ov_prot_code)); // RQ10 RQ8
    end
  end

  always_ff @(posedge clock_i or negedge rst_n_i) begin
    if (!rst_n_i) begin
      hit_r <= 6'h00;
    end else begin
      hit_r <= hit_nxt;
    end
  end

  assign thr.low_ov_warn_hit = hit_r[0];
  assign thr.low_ov_prot_hit = hit_r[1];
  assign thr.low_uv_warn_hit = hit_r[2];
  assign thr.high_uv_warn_hit = hit_r[3];
  assign thr.high_ov_warn_hit = hit_r[4];
  assign thr.high_ov_prot_hit = hit_r[5];
endmodule

// file: testbench/threshold_regs_properties.sv
// Port checks for the threshold register bank
`timescale 1ns/1ps
module threshold_regs_properties (
  input wire logic clock_i,
  input wire logic rst_n_i,
  input wire logic [7:0] cmd_code_i,
  input wire logic wr_stb_i,
  input wire logic [7:0] wr_data_i,
  input wire logic rd_stb_i,
  input wire logic write_protect_i,
  input wire logic [7:0] rd_data_o,
  input wire logic rd_valid_o,
  input wire logic cmd_unsupported_o,
  input wire logic sample_i,
  input wire logic hiccup_mode_i,
  input wire logic [1:0] fault_clear_i,
  input wire logic [1:0] fault_status_o,
  input wire logic [3:0] warning_o,
  input wire logic fault_flag_n_o,
  input wire logic switching_enable_o
);
  logic mapped;
  logic req;
  assign mapped = cmd_code_i inside {8'hB9, 8'hBA, 8'hBB};
  assign req = rd_stb_i | (wr_stb_i & !write_protect_i);
  default clocking cb @(posedge clock_i);
  endclocking
  default disable iff (!rst_n_i);
  a_read_answer: assert property (rd_stb_i && mapped |=> rd_valid_o)
    else $error("mapped read not answered");
  a_read_quiet: assert property (!rd_stb_i |=> !rd_valid_o)
    else $error("read answer without request");
  a_reserved_zero: assert property (rd_valid_o |-> rd_data_o[7:6] == 2'b00)
    else $error("reserved bits read nonzero");
  a_unmapped_flag: assert property (req && !mapped |=> cmd_unsupported_o)
    else $error("unmapped access not flagged");
  a_mapped_quiet: assert property (!(req && !mapped) |=> !cmd_unsupported_o)
    else $error("unsupported flag without cause");
  a_write_readback: assert property (wr_stb_i && !write_protect_i && mapped ##1
      rd_stb_i && !wr_stb_i && $stable(cmd_code_i) |=> rd_data_o == ($past(wr_data_i, 2) & 8'h3F))
    else $error("read after write lost the byte");
  a_flag_follows: assert property (fault_flag_n_o == (fault_status_o == 2'b00))
    else $error("fault flag disagrees with status");
  a_status_sticky: assert property (fault_clear_i == 2'b00 |=>
      (fault_status_o & $past(fault_status_o)) == $past(fault_status_o))
    else $error("fault status dropped without clear");
  a_trip_sampled: assert property ((fault_status_o & ~$past(fault_status_o)) != 2'b00
      |-> $past(sample_i, 2))
    else $error("fault set without a sample two cycles earlier");
  a_warn_hold: assert property (!sample_i |=> $stable(warning_o))
    else $error("warnings changed without a sample");
  a_hiccup_stop: assert property ($fell(switching_enable_o) |->
      $past(hiccup_mode_i) && fault_status_o != 2'b00)
    else $error("switching stopped without hiccup fault");
endmodule

bind bus_voltage_threshold_regs threshold_regs_properties chk (
  .clock_i(clock_i), .rst_n_i(rst_n_i), .cmd_code_i(cmd_code_i), .wr_stb_i(wr_stb_i),
  .wr_data_i(wr_data_i), .rd_stb_i(rd_stb_i), .write_protect_i(write_protect_i),
  .rd_data_o(rd_data_o), .rd_valid_o(rd_valid_o), .cmd_unsupported_o(cmd_unsupported_o),
  .sample_i(sample_i), .hiccup_mode_i(hiccup_mode_i), .fault_clear_i(fault_clear_i),
  .fault_status_o(fault_status_o), .warning_o(warning_o), .fault_flag_n_o(fault_flag_n_o),
  .switching_enable_o(switching_enable_o)
);

// file: testbench/mgmt_host_model.sv
// System controller model issuing register reads and writes
`timescale 1ns/1ps
module mgmt_host_model (
  input wire logic clock_i,
  input wire logic [7:0] rd_data_i,
  input wire logic rd_valid_i,
  input wire logic cmd_unsupported_i,
  output logic [7:0] cmd_code_o,
  output logic wr_stb_o,
  output logic [7:0] wr_data_o,
  output logic rd_stb_o
);
  initial begin
    cmd_code_o = 8'h00;
    wr_stb_o = 1'b0;
    wr_data_o = 8'h00;
    rd_stb_o = 1'b0;
  end
  // Waits one edge, then holds the byte across the taking edge
  task automatic write_byte(input logic [7:0] code, input logic [7:0] data);
    @(posedge clock_i);
    #1;
    cmd_code_o = code;
    wr_data_o = data;
    wr_stb_o = 1'b1;
    @(posedge clock_i);
    #1;
    wr_stb_o = 1'b0;
    wr_data_o = ~data;
  endtask
  // Starts at once, so it may follow a write back to back
  task automatic read_byte(input logic [7:0] code, output logic [7:0] data,
                           output logic unsup, output logic seen);
    cmd_code_o = code;
    rd_stb_o = 1'b1;
    @(posedge clock_i);
    #1;
    rd_stb_o = 1'b0;
    cmd_code_o = ~code;
    // Answer stands for one cycle after the taking edge
    seen = (rd_valid_i === 1'b1) || (cmd_unsupported_i === 1'b1);
    data = rd_data_i;
    unsup = cmd_unsupported_i;
    for (int i = 0; i < 4 && seen !== 1'b1; i++) begin
      @(posedge clock_i);
      #1;
      seen = (rd_valid_i === 1'b1) || (cmd_unsupported_i === 1'b1);
      data = rd_data_i;
      unsup = cmd_unsupported_i;
    end
    // Idle edge so a following read does not reassign the strobe at once
    @(posedge clock_i);
    #1;
  endtask
endmodule

// file: testbench/test_bus_voltage_threshold_regs.sv
// Self-checking bench for the bus voltage threshold registers
`timescale 1ns/1ps
module test_bus_voltage_threshold_regs;
  localparam int HICCUP = 16;
  localparam int LOW_OV [8] = '{1150, 1100, 1200, 1250, 1300, 1350, 1400, 1450};
  localparam int LOW_OP [8] = '{1500, 1400, 1300, 1600, 1700, 1800, 1900, 2000};
  localparam int LOW_UV [8] = '{850, 825, 800, 775, 750, 725, 875, 900};
  localparam int HIGH_UV [8] = '{750, 710, 670, 630, 580, 540, 790, 830};
  localparam int HIGH_OV [8] = '{1080, 1100, 1130, 1170, 1210, 1250, 1060, 1040};
  localparam int HIGH_OP [8] = '{1250, 1290, 1330, 1380, 1420, 1460, 1500, 1210};
  localparam logic [7:0] ADDRS [3] = '{8'hB9, 8'hBA, 8'hBB};
  logic clock_i, rst_n_i, wr_stb, rd_stb, write_protect, rd_valid, unsup, sample;
  logic hiccup, flag_n, sw_en;
  logic [7:0] cmd_code, wr_data, rd_data;
  logic [15:0] low_v, high_v, target;
  logic [1:0] fclr, fstat;
  logic [3:0] warn;
  logic [2:0] cc;
  int fails, comparisons, n;

  bus_voltage_threshold_regs #(.V_W(16), .HICCUP_CYCLES(HICCUP)) dut (
    .clock_i(clock_i), .rst_n_i(rst_n_i), .cmd_code_i(cmd_code), .wr_stb_i(wr_stb),
    .wr_data_i(wr_data), .rd_stb_i(rd_stb), .write_protect_i(write_protect),
    .rd_data_o(rd_data), .rd_valid_o(rd_valid), .cmd_unsupported_o(unsup),
    .sample_i(sample), .low_bus_voltage_i(low_v), .low_bus_target_i(target),
    .high_bus_voltage_i(high_v), .high_bus_target_i(target), .hiccup_mode_i(hiccup),
    .fault_clear_i(fclr), .fault_status_o(fstat), .warning_o(warn),
    .fault_flag_n_o(flag_n), .switching_enable_o(sw_en));
  mgmt_host_model host (.clock_i(clock_i), .rd_data_i(rd_data), .rd_valid_i(rd_valid),
    .cmd_unsupported_i(unsup), .cmd_code_o(cmd_code), .wr_stb_o(wr_stb),
    .wr_data_o(wr_data), .rd_stb_o(rd_stb));

  task automatic check(input string what, input logic [7:0] exp, input logic [7:0] got);
    comparisons++;
    if (got !== exp) begin
      fails++;
      $display("unexpected %s: expected %h, seen %h", what, exp, got);
    end
  endtask
  task automatic wrap_up();
    $display("comparisons %0d, mismatches %0d", comparisons, fails);
    if (fails == 0 && comparisons > 0) begin
      $display("Regression OK");
    end else begin
      $display("Regression broken");
    end
    $finish;
  endtask
  task automatic rd_check(input logic [7:0] code, input logic [7:0] exp, input logic eu);
    logic [7:0] d;
    logic u;
    logic s;
    host.read_byte(code, d, u, s);
    check("read answer", 8'h01, {7'h00, s});
    if (s !== 1'b1) begin
      wrap_up();
    end
    check("read data", exp, d);
    check("unsupported flag", {7'h00, eu}, {7'h00, u});
  endtask
  // One comparison cycle, warnings one edge later, faults two edges later
  task automatic samp(input logic [15:0] lv, input logic [15:0] hv, input logic [3:0] ew,
                      input logic [1:0] ef);
    low_v = lv;
    high_v = hv;
    sample = 1'b1;
    @(posedge clock_i);
    #1;
    sample = 1'b0;
    @(posedge clock_i);
    #1;
    check("warnings", {4'h0, ew}, {4'h0, warn});
    @(posedge clock_i);
    #1;
    check("fault status", {6'h00, ef}, {6'h00, fstat});
    check("fault flag", {7'h00, ef == 2'b00}, {7'h00, flag_n});
  endtask
  task automatic clr();
    fclr = 2'b11;
    @(posedge clock_i);
    #1;
    fclr = 2'b00;
    @(posedge clock_i);
    #1;
    check("cleared status", 8'h00, {6'h00, fstat});
    check("cleared flag", 8'h01, {7'h00, flag_n});
  endtask

  initial begin
    clock_i = 1'b0;
    forever #2 clock_i = ~clock_i;
  end
  initial begin
    #100000;
    fails++;
    $display("unexpected run length: expected end, seen none");
    wrap_up();
  end
  initial begin
    rst_n_i = 1'b0;
    write_protect = 1'b0;
    sample = 1'b0;
    low_v = 16'h03E8;
    high_v = 16'h03E8;
    target = 16'h03E8;
    hiccup = 1'b0;
    fclr = 2'b00;
    repeat (4) @(posedge clock_i);
    #1;
    rst_n_i = 1'b1;
    repeat (3) @(posedge clock_i);
    #1;
    foreach (ADDRS[i]) rd_check(ADDRS[i], 8'h00, 1'b0);
    foreach (ADDRS[i]) begin
      host.write_byte(ADDRS[i], 8'hFF);
      rd_check(ADDRS[i], 8'h3F, 1'b0);
    end
    rd_check(8'hBC, 8'h00, 1'b1);
    host.write_byte(8'hBC, 8'h12);
    check("unsupported flag", 8'h01, {7'h00, unsup});
    write_protect = 1'b1;
    host.write_byte(8'hB9, 8'h2A);
    write_protect = 1'b0;
    rd_check(8'hB9, 8'h3F, 1'b0);
    $display("test register access done");
    for (int c = 0; c < 8; c++) begin
      cc = c[2:0];
      foreach (ADDRS[i]) host.write_byte(ADDRS[i], {2'b00, cc, cc});
      samp(16'(LOW_OV[c] + 1), 16'(HIGH_OV[c] + 1), 4'b1001, 2'b00);
      samp(16'(LOW_OV[c]), 16'(HIGH_OV[c]), 4'b0000, 2'b00);
      samp(16'(LOW_UV[c] - 1), 16'(HIGH_UV[c] - 1), 4'b0110, 2'b00);
      samp(16'(LOW_UV[c]), 16'(HIGH_UV[c]), 4'b0000, 2'b00);
      samp(16'(LOW_OP[c]), 16'(HIGH_OP[c]), 4'b1001, 2'b00);
      samp(16'(LOW_OP[c] + 1), 16'(HIGH_OP[c] + 1), 4'b1001, 2'b11);
      samp(16'd1000, 16'd1000, 4'b0000, 2'b11);
      clr();
      check("switching", 8'h01, {7'h00, sw_en});
    end
    $display("test threshold decode done");
    hiccup = 1'b1;
    host.write_byte(8'hB9, 8'h00);
    samp(16'd1501, 16'd1000, 4'b0001, 2'b01);
    check("switching", 8'h00, {7'h00, sw_en});
    samp(16'd1000, 16'd1000, 4'b0000, 2'b01);
    clr();
    n = 0;
    while (sw_en !== 1'b1 && n < 4 * HICCUP) begin
      @(posedge clock_i);
      #1;
      n++;
    end
    check("switching", 8'h01, {7'h00, sw_en});
    check("restart wait", 8'h01, {7'h00, n >= HICCUP / 2});
    if (n == 4 * HICCUP) begin
      wrap_up();
    end
    $display("test hiccup done");
    wrap_up();
  end
endmodule
